// ==== verilog/ics_top.sv ====
`timescale 1ns/1ps
module ics_top
(
	// Clock and reset.
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	// AHB-Lite slave.
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic      [31:0]          hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	// Pins and analog comparator.
	input  wire logic                 ext_pin_0,
	input  wire logic                 ext_pin_1,
	input  wire logic                 comparator_low,
	// Power mode and peripheral events.
	input  wire logic                 idle_mode,
	input  wire logic                 sleep_mode,
	input  wire logic                 deep_sleep_mode,
	input  wire ics_pkg::ics_events_t events,
	// Core side.
	input  wire logic                 irq_take,
	output logic                      irq_req,
	output logic      [3:0]           irq_vec,
	output logic                      wake,
	// Analog control and interrupt line.
	output logic                      monitor_power,
	output logic      [11:0]          threshold_mv,
	output logic                      irq
);

	logic [7:0]  monctl_q, edge_q, pri0_q, pri1_q, pri2_q;
	logic [7:0]  grp0_q, grp1_q, grp2_q, stat_q, mask_q;
	logic [7:0]  addr_q;
	logic        addr_ok_q, wr_pend_q, rd_pend_q;
	logic [31:0] hrdata_q;
	logic        hreadyout_q;
	logic [1:0]  pin_s1_q, pin_s2_q, pin_prev_q, pin_set;
	logic        low_s1_q, low_s2_q, low_out_q, mon_pwr_q;
	logic [7:0]  low_cnt_q;
	logic        low_set;
	logic        irq_req_q, wake_q, irq_q;
	logic [3:0]  irq_vec_q;
	logic [11:0] thr_q;
	logic        take;
	logic [ics_pkg::NUM_VEC-1:0] pend;
	logic [3:0]  vec_d;
	logic [2:0]  grp_set;
	logic [7:0]  wd;
	logic [7:0]  rmux;
	logic [7:0]  pri0_clr;

	assign hrdata    = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp     = 1'b0;
	assign irq_req   = irq_req_q;
	assign irq_vec   = irq_vec_q;
	assign wake      = wake_q;
	assign monitor_power = mon_pwr_q;
	assign threshold_mv  = thr_q;
	assign irq       = irq_q;
	assign wd        = hwdata[7:0];

	// Bus slave: writes have no wait state, reads one, so read data
	// always reflects a write that completed just before.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			addr_q      <= 8'h00;
			addr_ok_q   <= 1'b0;
			wr_pend_q   <= 1'b0;
			rd_pend_q   <= 1'b0;
			hreadyout_q <= 1'b1;
			hrdata_q    <= 32'h0000_0000;
		end
		else if (rd_pend_q)
		begin
			rd_pend_q   <= 1'b0;
			hreadyout_q <= 1'b1;
			hrdata_q    <= {24'h00_0000, rmux};
		end
		else if (hready)
		begin
			wr_pend_q <= hsel && htrans[1] && hwrite;
			rd_pend_q <= hsel && htrans[1] && !hwrite;
			hreadyout_q <= !(hsel && htrans[1] && !hwrite);
			addr_q    <= haddr[7:0];
			addr_ok_q <= (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'h0);
		end
	end

	function automatic logic wr_at(input logic [7:0] a);
		wr_at = wr_pend_q && hready && addr_ok_q && (addr_q == a);
	endfunction

	always_comb
	begin
		rmux = 8'h00;
		if (addr_ok_q)
		begin
			unique case (addr_q)
				ics_pkg::A_MONCTL: rmux = {2'h0, low_out_q, monctl_q[4:0]};
				ics_pkg::A_EDGE:   rmux = edge_q;
				ics_pkg::A_PRI0:   rmux = pri0_q;
				ics_pkg::A_PRI1:   rmux = pri1_q;
				ics_pkg::A_PRI2:   rmux = pri2_q;
				ics_pkg::A_GRP0:   rmux = grp0_q;
				ics_pkg::A_GRP1:   rmux = grp1_q;
				ics_pkg::A_GRP2:   rmux = grp2_q;
				ics_pkg::A_STAT:   rmux = stat_q;
				ics_pkg::A_MASK:   rmux = mask_q;
				default:           rmux = 8'h00;
			endcase
		end
	end

	// Pin synchronisers and edge detection.
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_pin
			logic [1:0] sel;
			logic       rise, fall;
			assign sel  = edge_q[2*gi+1:2*gi];
			assign rise = pin_s2_q[gi] && !pin_prev_q[gi];
			assign fall = !pin_s2_q[gi] && pin_prev_q[gi];
			always_comb
			begin
				unique case (sel)
					ics_pkg::EDGE_OFF:  pin_set[gi] = 1'b0;
					ics_pkg::EDGE_RISE: pin_set[gi] = rise;
					ics_pkg::EDGE_FALL: pin_set[gi] = fall;
					ics_pkg::EDGE_BOTH: pin_set[gi] = rise || fall;
				endcase
			end
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_s1_q   <= 2'h0;
			pin_s2_q   <= 2'h0;
			pin_prev_q <= 2'h0;
		end
		else
		begin
			pin_s1_q   <= {ext_pin_1, ext_pin_0};
			pin_s2_q   <= pin_s1_q;
			pin_prev_q <= pin_s2_q;
		end
	end

	// Supply monitor. The output is held low while the detector is
	// unpowered, so a stale comparator level never raises a request.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			low_s1_q  <= 1'b0;
			low_s2_q  <= 1'b0;
			mon_pwr_q <= 1'b0;
			low_out_q <= 1'b0;
			thr_q     <= 12'h000;
		end
		else
		begin
			low_s1_q  <= comparator_low;
			low_s2_q  <= low_s1_q;
			mon_pwr_q <= monctl_q[ics_pkg::MON_ON] &&
				!sleep_mode && !deep_sleep_mode;
			low_out_q <= mon_pwr_q && low_s2_q;
			thr_q     <= ics_pkg::threshold_mv(monctl_q[ics_pkg::THR_MSB:0]);
		end
	end

	// A dip shorter than the delay restarts the count and sets nothing.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			low_cnt_q <= 8'h00;
		else if (!low_out_q)
			low_cnt_q <= 8'h00;
		else if (low_cnt_q != ics_pkg::LOW_IRQ_CYC)
			low_cnt_q <= low_cnt_q + 8'h01;
	end

	assign low_set = low_out_q &&
		(low_cnt_q == ics_pkg::LOW_IRQ_CYC - 8'h01);

	// Group requests follow enabled member flags.
	assign grp_set[0] = |(grp0_q[7:4] & grp0_q[3:0]);
	assign grp_set[1] = |(grp1_q[5:4] & grp1_q[1:0]);
	assign grp_set[2] = |(grp2_q[6:4] & grp2_q[2:0]);

	// Vector arbitration.
	assign pend = {pri2_q[7:4] & pri2_q[3:0],
		pri1_q[7:5] & pri1_q[3:1],
		pri1_q[ics_pkg::TB1_REQ] && pri1_q[ics_pkg::TB1_EN],
		pri0_q[ics_pkg::TB0_REQ] && pri0_q[ics_pkg::TB0_EN],
		pri0_q[ics_pkg::PIN1_REQ] && pri0_q[ics_pkg::PIN1_EN],
		pri0_q[ics_pkg::PIN0_REQ] && pri0_q[ics_pkg::PIN0_EN]};

	always_comb
	begin
		vec_d = 4'h0;
		for (int i = ics_pkg::NUM_VEC - 1; i >= 0; i--)
		begin
			if (pend[i])
				vec_d = 4'(i);
		end
	end

	assign take = irq_take && irq_req_q;

	always_comb
	begin
		pri0_clr = 8'h00;
		if (take)
		begin
			pri0_clr[ics_pkg::GLOBAL_EN] = 1'b1;
			if (irq_vec_q == ics_pkg::VEC_PIN0)
				pri0_clr[ics_pkg::PIN0_REQ] = 1'b1;
			if (irq_vec_q == ics_pkg::VEC_PIN1)
				pri0_clr[ics_pkg::PIN1_REQ] = 1'b1;
		end
	end

	// The request drops in the cycle after a take, since take masks it at
	// that edge; global enable, cleared at the same edge, keeps it low.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			irq_req_q <= 1'b0;
			irq_vec_q <= 4'h0;
		end
		else
		begin
			irq_req_q <= pri0_q[ics_pkg::GLOBAL_EN] && !take && |pend;
			irq_vec_q <= vec_d;
		end
	end

	// Control and flag registers: hardware sets win over clears.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			monctl_q <= ics_pkg::RST_REG;
			edge_q   <= ics_pkg::RST_REG;
			pri0_q   <= ics_pkg::RST_REG;
			pri1_q   <= ics_pkg::RST_REG;
			pri2_q   <= ics_pkg::RST_REG;
			grp0_q   <= ics_pkg::RST_REG;
			grp1_q   <= ics_pkg::RST_REG;
			grp2_q   <= ics_pkg::RST_REG;
		end
		else
		begin
			monctl_q <= (wr_at(ics_pkg::A_MONCTL) ? wd : monctl_q) &
				ics_pkg::M_MONCTL;
			edge_q   <= (wr_at(ics_pkg::A_EDGE) ? wd : edge_q) &
				ics_pkg::M_EDGE;
			pri0_q   <= (((wr_at(ics_pkg::A_PRI0) ? wd : pri0_q) & ~pri0_clr) |
				{1'b0, events.timebase0, pin_set, 4'h0}) &
				ics_pkg::M_PRI0;
			pri1_q   <= (wr_at(ics_pkg::A_PRI1) ? wd : pri1_q) |
				{grp_set, events.timebase1, 4'h0};
			pri2_q   <= (wr_at(ics_pkg::A_PRI2) ? wd : pri2_q) |
				{events.pri2_src, 4'h0};
			grp0_q   <= (wr_at(ics_pkg::A_GRP0) ? wd : grp0_q) |
				{events.grp0_member, 4'h0};
			grp1_q   <= ((wr_at(ics_pkg::A_GRP1) ? wd : grp1_q) |
				{2'h0, events.grp1_member, 4'h0}) & ics_pkg::M_GRP1;
			grp2_q   <= ((wr_at(ics_pkg::A_GRP2) ? wd : grp2_q) |
				{1'b0, low_set, events.tx_margin,
				events.burst_done, 4'h0}) & ics_pkg::M_GRP2;
		end
	end

	// Wake only on a fresh low-supply request; one already set by
	// software gives no edge and so no wake.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			wake_q <= 1'b0;
		else
			wake_q <= idle_mode && low_set && !grp2_q[ics_pkg::LOW_REQ];
	end

	// Sticky event status, write one to clear, masked onto one line.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			stat_q <= ics_pkg::RST_REG;
			mask_q <= ics_pkg::RST_REG;
			irq_q  <= 1'b0;
		end
		else
		begin
			stat_q <= ((stat_q & ~(wr_at(ics_pkg::A_STAT) ? wd : 8'h00)) |
				{4'h0, take, low_set, pin_set}) & ics_pkg::M_STAT;
			if (wr_at(ics_pkg::A_MASK))
				mask_q <= wd & ics_pkg::M_STAT;
			irq_q  <= |(stat_q & mask_q);
		end
	end

endmodule

// ==== verilog/ics_pkg.sv ====
package ics_pkg;

	// Register byte addresses.
	localparam logic [7:0] A_MONCTL = 8'h00;
	localparam logic [7:0] A_EDGE   = 8'h04;
	localparam logic [7:0] A_PRI0   = 8'h08;
	localparam logic [7:0] A_PRI1   = 8'h0c;
	localparam logic [7:0] A_PRI2   = 8'h10;
	localparam logic [7:0] A_GRP0   = 8'h14;
	localparam logic [7:0] A_GRP1   = 8'h18;
	localparam logic [7:0] A_GRP2   = 8'h1c;
	localparam logic [7:0] A_STAT   = 8'h20;
	localparam logic [7:0] A_MASK   = 8'h24;

	// Implemented-bit masks; all registers reset to zero.
	localparam logic [7:0] M_MONCTL = 8'h1f;
	localparam logic [7:0] M_EDGE   = 8'h0f;
	localparam logic [7:0] M_PRI0   = 8'h7f;
	localparam logic [7:0] M_FULL   = 8'hff;
	localparam logic [7:0] M_GRP1   = 8'h33;
	localparam logic [7:0] M_GRP2   = 8'h77;
	localparam logic [7:0] M_STAT   = 8'h0f;
	localparam logic [7:0] RST_REG  = 8'h00;

	// Field positions.
	localparam int MON_OUT    = 5;
	localparam int MON_ON     = 4;
	localparam int THR_MSB    = 2;
	localparam int GLOBAL_EN  = 0;
	localparam int PIN0_EN    = 1;
	localparam int PIN1_EN    = 2;
	localparam int TB0_EN     = 3;
	localparam int PIN0_REQ   = 4;
	localparam int PIN1_REQ   = 5;
	localparam int TB0_REQ    = 6;
	localparam int TB1_EN     = 0;
	localparam int TB1_REQ    = 4;
	localparam int GRP_EN_LSB = 1;
	localparam int GRP_RQ_LSB = 5;
	localparam int LOW_REQ    = 6;
	localparam int REQ_LSB    = 4;

	// Status bits of the sticky event register.
	localparam int ST_PIN0 = 0;
	localparam int ST_PIN1 = 1;
	localparam int ST_LOW  = 2;
	localparam int ST_TAKE = 3;

	// Edge select codes.
	localparam logic [1:0] EDGE_OFF  = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	// Vector indices: lower index wins.
	localparam int         NUM_VEC  = 11;
	localparam logic [3:0] VEC_PIN0 = 4'h0;
	localparam logic [3:0] VEC_PIN1 = 4'h1;

	// Timing.
	localparam int CLK_PERIOD_NS  = 25;
	localparam int LOW_IRQ_DLY_NS = 1000;
	localparam logic [7:0] LOW_IRQ_CYC = 8'((LOW_IRQ_DLY_NS +
		CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	typedef struct packed {
		logic       timebase0;
		logic       timebase1;
		logic [3:0] grp0_member;
		logic [1:0] grp1_member;
		logic       tx_margin;
		logic       burst_done;
		logic [3:0] pri2_src;
	} ics_events_t;

	// Threshold code to millivolts.
	function automatic logic [11:0] threshold_mv(input logic [2:0] code);
		unique case (code)
			3'h0: threshold_mv = 12'd2400;
			3'h1: threshold_mv = 12'd2000;
			3'h2: threshold_mv = 12'd2200;
			3'h3: threshold_mv = 12'd2400;
			3'h4: threshold_mv = 12'd2700;
			3'h5: threshold_mv = 12'd2900;
			3'h6: threshold_mv = 12'd3000;
			3'h7: threshold_mv = 12'd3300;
		endcase
	endfunction

endpackage

// ==== verification/ics_monitor.sv ====
`timescale 1ns/1ps
module ics_monitor
(
	// Clock and reset.
	input wire logic        hclk,
	input wire logic        hresetn,
	// Bus.
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Monitor, power modes and core.
	input wire logic        comparator_low,
	input wire logic        idle_mode,
	input wire logic        sleep_mode,
	input wire logic        deep_sleep_mode,
	input wire logic        irq_take,
	input wire logic        irq_req,
	input wire logic        wake,
	input wire logic        monitor_power,
	input wire logic [11:0] threshold_mv
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic [7:0] run_q;
	logic [3:0] seen_q;

	// A long low run arms a short window, so the check does not hinge on
	// the exact depth of the synchronisers.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			run_q  <= 8'h00;
			seen_q <= 4'h0;
		end
		else
		begin
			run_q  <= (comparator_low && monitor_power) ?
				run_q + 8'(run_q != 8'hff) : 8'h00;
			seen_q <= (run_q >= ics_pkg::LOW_IRQ_CYC - 8'd4) ? 4'h8 :
				seen_q - 4'(seen_q != 4'h0);
		end
	end

	property p_thr;
		$past(hresetn) |-> threshold_mv inside {12'd2000, 12'd2200,
			12'd2400, 12'd2700, 12'd2900, 12'd3000, 12'd3300};
	endproperty
	a_thr: assert property (p_thr) else $error("bad threshold");
	property p_off;
		sleep_mode || deep_sleep_mode |=> !monitor_power;
	endproperty
	a_off: assert property (p_off) else $error("monitor on in sleep");
	property p_low;
		wake |-> seen_q != 4'h0;
	endproperty
	a_low: assert property (p_low) else $error("early low request");
	property p_wake;
		wake |-> $past(idle_mode) ##1 !wake;
	endproperty
	a_wake: assert property (p_wake) else $error("bad wake");
	property p_take;
		irq_take && irq_req |=> !irq_req;
	endproperty
	a_take: assert property (p_take) else $error("request after take");
	property p_rd;
		hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout;
	endproperty
	a_rd: assert property (p_rd) else $error("read wait wrong");
	property p_wr;
		hsel && hready && htrans[1] && hwrite |=> hreadyout;
	endproperty
	a_wr: assert property (p_wr) else $error("write wait wrong");
	property p_resp;
		hresp == 1'b0;
	endproperty
	a_resp: assert property (p_resp) else $error("response not okay");
endmodule

bind ics_top ics_monitor ics_monitor_inst (.hclk, .hresetn, .hsel,
	.htrans, .hwrite, .hready, .hreadyout, .hresp, .comparator_low,
	.idle_mode, .sleep_mode, .deep_sleep_mode, .irq_take, .irq_req,
	.wake, .monitor_power, .threshold_mv);

// ==== verification/ics_core_model.sv ====
`timescale 1ns/1ps
// Core side: takes a pending vector after a chosen latency.
module ics_core_model
(
	// Clock and reset.
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Request from the controller.
	input  wire logic       irq_req,
	input  wire logic [3:0] irq_vec,
	// Test controls.
	input  wire logic       allow,
	input  wire logic [3:0] lat,
	// Acceptance.
	output logic            irq_take,
	output logic      [3:0] took
);
	logic [3:0] cnt_q;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			irq_take <= 1'b0;
			took     <= 4'h0;
			cnt_q    <= 4'h0;
		end
		else if (irq_take || !irq_req || !allow)
		begin
			irq_take <= 1'b0;
			cnt_q    <= 4'h0;
		end
		else if (cnt_q >= lat)
		begin
			irq_take <= 1'b1;
			took     <= irq_vec;
		end
		else
			cnt_q <= cnt_q + 4'h1;
	end
endmodule

// ==== verification/ics_top_tb.sv ====
`timescale 1ns/1ps
module ics_top_tb;
	logic                 hclk, hresetn, hsel, hwrite, hrdy, hresp;
	logic                 irq_take, irq_req, wake, mpw, irq, allow;
	logic                 cmp, idle, slp, dslp;
	logic [1:0]           htrans, pins;
	logic [2:0]           hsize;
	logic [3:0]           vec, took, lat;
	logic [11:0]          thr;
	logic [31:0]          haddr, hwdata, hrdata, seed;
	ics_pkg::ics_events_t ev;
	int                   errors, comparisons, wakes;
	logic [7:0]           ra [9] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14,
		8'h18, 8'h1c, 8'h24, 8'h0c};
	logic [7:0]           rm [9] = '{8'h1f, 8'h0f, 8'h7f, 8'hff, 8'hff,
		8'h33, 8'h77, 8'h0f, 8'hff};

	ics_top ics_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hrdy), .hrdata, .hreadyout(hrdy), .hresp,
		.ext_pin_0(pins[0]), .ext_pin_1(pins[1]), .comparator_low(cmp),
		.idle_mode(idle), .sleep_mode(slp), .deep_sleep_mode(dslp),
		.events(ev), .irq_take, .irq_req, .irq_vec(vec), .wake,
		.monitor_power(mpw), .threshold_mv(thr), .irq);
	ics_core_model ics_core_model_inst (.hclk, .hresetn, .irq_req,
		.irq_vec(vec), .allow, .lat, .irq_take, .took);

	function automatic logic [31:0] nxt(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
	endfunction
	function automatic logic [11:0] mv(input logic [2:0] c);
		logic [11:0] t [8] = '{12'd2400, 12'd2000, 12'd2200, 12'd2400,
			12'd2700, 12'd2900, 12'd3000, 12'd3300};
		return t[c];
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, g);
		comparisons++;
		if (g !== e)
		begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			errors++;
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, d,
		output logic [31:0] r);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (!hrdy);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (!hrdy);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rd(input string nm, input logic [7:0] a, e);
		logic [31:0] r;
		bus(1'b0, a, 8'h00, r);
		chk(nm, {24'h0, e}, r);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	always @(posedge hclk)
		if (wake === 1'b1)
			wakes++;
	initial
	begin
		repeat (20000) @(posedge hclk);
		errors++;
		report_and_stop();
	end

	initial
	begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		{pins, cmp, idle, slp, dslp, allow, lat} = '0;
		hsize = 3'h2;
		ev = '0;
		seed = 32'h07f4;
		errors = 0;
		comparisons = 0;
		wakes = 0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 9; i++)
			rd("reset", ra[i], 8'h00);
		wr(8'h28, 8'hff);
		rd("unmapped", 8'h28, 8'h00);
		for (int i = 0; i < 9; i++)
		begin
			seed = nxt(seed);
			wr(ra[i], seed[7:0]);
			rd("readback", ra[i], seed[7:0] & rm[i]);
			wr(ra[i], 8'h00);
		end
		for (int c = 0; c < 8; c++)
		begin
			wr(8'h00, 8'(c));
			repeat (2) @(posedge hclk);
			chk("threshold", {20'h0, mv(3'(c))}, {20'h0, thr});
		end
		$display("test registers done");
		cmp  <= 1'b1;
		idle <= 1'b1;
		wr(8'h00, 8'h10);
		repeat (5) @(posedge hclk);
		chk("power", 32'h1, {31'h0, mpw});
		rd("low out", 8'h00, 8'h30);
		rd("early", 8'h1c, 8'h00);
		repeat (45) @(posedge hclk);
		rd("low flag", 8'h1c, 8'h40);
		chk("wake", 32'h1, wakes);
		slp <= 1'b1;
		repeat (3) @(posedge hclk);
		chk("sleep", 32'h0, {31'h0, mpw});
		slp  <= 1'b0;
		dslp <= 1'b1;
		repeat (3) @(posedge hclk);
		rd("deep", 8'h00, 8'h10);
		dslp <= 1'b0;
		repeat (60) @(posedge hclk);
		chk("no wake", 32'h1, wakes);
		rd("status", 8'h20, 8'h04);
		wr(8'h24, 8'h04);
		repeat (2) @(posedge hclk);
		chk("irq", 32'h1, {31'h0, irq});
		wr(8'h24, 8'h00);
		repeat (2) @(posedge hclk);
		chk("masked", 32'h0, {31'h0, irq});
		wr(8'h24, 8'h04);
		wr(8'h20, 8'h04);
		repeat (2) @(posedge hclk);
		chk("cleared", 32'h0, {31'h0, irq});
		cmp <= 1'b0;
		wr(8'h00, 8'h00);
		wr(8'h1c, 8'h00);
		repeat (2) @(posedge hclk);
		chk("off", 32'h0, {31'h0, mpw});
		$display("test monitor done");
		wr(8'h0c, 8'h00);
		ev.timebase1 <= 1'b1;
		ev.tx_margin <= 1'b1;
		@(posedge hclk);
		ev <= '0;
		repeat (3) @(posedge hclk);
		rd("margin flag", 8'h1c, 8'h20);
		rd("tb1 flag", 8'h0c, 8'h10);
		wr(8'h1c, 8'h22);
		repeat (3) @(posedge hclk);
		rd("group", 8'h0c, 8'h90);
		ev.grp0_member <= 4'h9;
		ev.grp1_member <= 2'h2;
		ev.burst_done  <= 1'b1;
		ev.pri2_src    <= 4'h6;
		@(posedge hclk);
		ev <= '0;
		repeat (3) @(posedge hclk);
		rd("group0 flags", 8'h14, 8'h90);
		rd("group1 flags", 8'h18, 8'h20);
		rd("burst flag", 8'h1c, 8'h32);
		rd("primary2 flags", 8'h10, 8'h60);
		$display("test groups done");
		for (int p = 0; p < 2; p++)
			for (int c = 0; c < 4; c++)
			begin
				wr(8'h04, 8'(c << (2 * p)));
				wr(8'h08, 8'h00);
				pins[p] <= 1'b1;
				repeat (8) @(posedge hclk);
				rd("rise", 8'h08, c[0] ? 8'(8'h10 << p) : 8'h00);
				wr(8'h08, 8'h00);
				pins[p] <= 1'b0;
				repeat (8) @(posedge hclk);
				rd("fall", 8'h08, c[1] ? 8'(8'h10 << p) : 8'h00);
			end
		wr(8'h08, 8'h24);
		repeat (4) @(posedge hclk);
		chk("blocked", 32'h0, {31'h0, irq_req});
		seed = nxt(seed);
		lat   <= seed[3:0];
		allow <= 1'b1;
		wr(8'h08, 8'h25);
		repeat (24) @(posedge hclk);
		ev.timebase0 <= 1'b1;
		@(posedge hclk);
		ev <= '0;
		repeat (3) @(posedge hclk);
		rd("after take", 8'h08, 8'h44);
		chk("vector", {28'h0, ics_pkg::VEC_PIN1}, {28'h0, took});
		wr(8'h04, 8'h01);
		wr(8'h08, 8'h03);
		pins[0] <= 1'b1;
		repeat (24) @(posedge hclk);
		rd("pin0 take", 8'h08, 8'h02);
		chk("vector 0", {28'h0, ics_pkg::VEC_PIN0}, {28'h0, took});
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rd("reset again", 8'h08, 8'h00);
		pins[0] <= 1'b0;
		repeat (8) @(posedge hclk);
		rd("pin0 off", 8'h08, 8'h00);
		$display("test pins done");
		report_and_stop();
	end
endmodule
